// file: ssiap_device.sv
// Purpose: Encoder end of the serial link; latches and shifts out position.
// Assumes: Sensor position and fault flags arrive on clk_sys_i; zero and
//          direction inputs are pins and are synchronised here.
// Notes: Shift logic runs on the link clock; monoflop runs on clk_sys_i.
`timescale 1ns/1ps

// Operation
// - First falling clock edge captures position word.
// - MSB driven from following rising edge.
// - Each later rising edge sends next bit.
// - Master gives one rising edge per bit.
// - Surplus clocks send zeros after the word.
// - After monoflop expiry data returns high, ready.
// - Position sent as binary or Gray.
// - Frame is resolution bits plus status bit.
// - MSB first, LSB then status bit last.
// - Status bit high when no fault active.
// - Scale, supply or memory fault clears status.
// - Link clock between 100 kHz and 2 MHz.
// - Master pauses at least 16 us between bursts.
// - Master slows clock on long cables.
// - Position range tops at two-power minus one.
// - Standard direction counts up toward maximum.
// - Zero input held 100 us zeroes position.
// - Direction input high reverses counting.
module ssiap_device
    import ssiap_pkg::*;
#(
    parameter int RES_BITS = RES_BITS_DEF,
    parameter bit GRAY_CODE = GRAY_CODE_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [RES_BITS-1:0] raw_pos_i,
    input wire logic pos_valid_i,
    input wire logic supply_ok_i,
    input wire logic nvm_ok_i,
    input wire logic zero_set_i,
    input wire logic dir_sel_i,
    output logic link_ready_o,
    ssiap_link_if.dev link
);

    // ==========================================================================
    // Local types and helpers
    localparam int FRAME_LEN = RES_BITS + STATUS_BITS;
    localparam int CNT_W = $clog2(FRAME_LEN + 1);
    localparam int MONO_W = $clog2(MONOFLOP_CYC + 1);
    localparam int ZERO_W = $clog2(ZERO_HOLD_CYC + 1);

    typedef enum logic [1:0] {
        ST_READY,
        ST_FRAME,
        ST_CLEAR
    } ssiap_dev_state_type;

    function automatic logic [RES_BITS-1:0] bin_to_gray(input logic [RES_BITS-1:0] b);
        bin_to_gray = b ^ (b >> 1);
    endfunction

    // ==========================================================================
    // Pin synchronisers on the system clock
    logic zero_m_q;
    logic zero_s_q;
    logic dir_m_q;
    logic dir_s_q;
    logic sclk_m_q;
    logic sclk_s_q;
    logic sclk_prev_q;
    logic started_m_q;
    logic started_s_q;
    logic started_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_m_q <= 1'b0;
            zero_s_q <= 1'b0;
            dir_m_q <= 1'b0;
            dir_s_q <= 1'b0;
            sclk_m_q <= 1'b1;
            sclk_s_q <= 1'b1;
            sclk_prev_q <= 1'b1;
            started_m_q <= 1'b0;
            started_s_q <= 1'b0;
        end else begin
            zero_m_q <= zero_set_i;
            zero_s_q <= zero_m_q;
            dir_m_q <= dir_sel_i;
            dir_s_q <= dir_m_q;
            sclk_m_q <= link.sclk;
            sclk_s_q <= sclk_m_q;
            sclk_prev_q <= sclk_s_q;
            started_m_q <= started_q;
            started_s_q <= started_m_q;
        end
    end

    // ==========================================================================
    // Position orientation and zero setting
    logic [RES_BITS-1:0] oriented_pos;
    logic [RES_BITS-1:0] zero_off_q;
    logic [ZERO_W-1:0] zero_cnt_q;
    logic zero_prev_q;
    logic zero_release;

    // Two's complement negation reverses the count; wrapping at the width keeps
    // the value within 0 up to all ones.
    assign oriented_pos = dir_s_q ? (~raw_pos_i + 1'b1) : raw_pos_i;
    assign zero_release = zero_prev_q && !zero_s_q && (zero_cnt_q >= ZERO_W'(ZERO_HOLD_CYC));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_prev_q <= 1'b0;
            zero_cnt_q <= '0;
        end else begin
            zero_prev_q <= zero_s_q;
            if (!zero_s_q) begin
                zero_cnt_q <= '0;
            end else if (zero_cnt_q < ZERO_W'(ZERO_HOLD_CYC)) begin
                zero_cnt_q <= zero_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            zero_off_q <= '0;
        end else if (zero_release) begin
            zero_off_q <= oriented_pos;
        end
    end

    // ==========================================================================
    // Word presented to the link
    logic [RES_BITS-1:0] rel_pos;
    logic [RES_BITS-1:0] coded_pos;
    logic status_ok;
    logic [FRAME_LEN-1:0] word_hold_q;

    assign rel_pos = oriented_pos - zero_off_q;
    assign coded_pos = GRAY_CODE ? bin_to_gray(rel_pos) : rel_pos;
    assign status_ok = pos_valid_i && supply_ok_i && nvm_ok_i;

    // ==========================================================================
    // Monoflop and re-arm control
    ssiap_dev_state_type state_q;
    logic [MONO_W-1:0] mono_cnt_q;
    logic clr_q;
    logic mono_done;

    assign mono_done = (mono_cnt_q >= MONO_W'(MONOFLOP_CYC));

    // Every clock level change restarts the monoflop, so it measures from the
    // last edge of the burst.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mono_cnt_q <= '0;
        end else if (sclk_s_q != sclk_prev_q) begin
            mono_cnt_q <= '0;
        end else if (!mono_done) begin
            mono_cnt_q <= mono_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_READY;
            clr_q <= 1'b0;
        end else begin
            case (state_q)
                ST_READY: begin
                    if (started_s_q) begin
                        state_q <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (mono_done && sclk_s_q) begin
                        state_q <= ST_CLEAR;
                        clr_q <= 1'b1;
                    end
                end
                ST_CLEAR: begin
                    if (!started_s_q) begin
                        state_q <= ST_READY;
                        clr_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_READY;
                    clr_q <= 1'b0;
                end
            endcase
        end
    end

    // The held word only moves while no frame is under way, so the link side
    // sees a settled value at its capture edge. A master that breaks the pause
    // may still catch it mid-update; that is the cost of not stalling the link.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_hold_q <= '0;
        end else if (state_q == ST_READY && !started_s_q && sclk_s_q) begin
            word_hold_q <= {coded_pos, status_ok};
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_ready_o <= 1'b0;
        end else begin
            link_ready_o <= (state_q == ST_READY) && !started_s_q;
        end
    end

    // ==========================================================================
    // Link clock domain
    logic link_rst_n;
    logic [FRAME_LEN-1:0] word_q;
    logic [CNT_W-1:0] bit_cnt_q;
    logic data_q;

    // The clear pulse re-arms the link side without needing link clock edges,
    // which stop between frames.
    assign link_rst_n = rst_n_i && !clr_q;

    always_ff @(negedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            started_q <= 1'b0;
            word_q <= '0;
        end else if (!started_q) begin
            started_q <= 1'b1;
            word_q <= word_hold_q;
        end
    end

    // Falling edges after the first, and any during the clear, leave the
    // captured word untouched.
    always_ff @(posedge link.sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            data_q <= 1'b1;
            bit_cnt_q <= '0;
        end else if (started_q) begin
            if (bit_cnt_q < CNT_W'(FRAME_LEN)) begin
                data_q <= word_q[FRAME_LEN - 1 - int'(bit_cnt_q)];
                bit_cnt_q <= bit_cnt_q + 1'b1;
            end else begin
                data_q <= 1'b0;
            end
        end
    end

    assign link.sdata = data_q;

endmodule

// file: ssiap_pkg.sv
// Purpose: Shared constants for the absolute position serial link, both ends.
// Assumes: System clock of 40 MHz at both ends.
// Notes: Times are kept in their own unit; cycle counts are derived here.

package ssiap_pkg;

    // ==========================================================================
    // Clocks and word layout
    localparam int SYS_CLK_KHZ = 40000;
    localparam int RES_BITS_DEF = 13;
    localparam int RES_BITS_MIN = 12;
    localparam int RES_BITS_MAX = 14;
    localparam int STATUS_BITS = 1;
    localparam bit GRAY_CODE_DEF = 1'b0;
    localparam int NS_PER_MS = 1000000;
    localparam int US_PER_MS = 1000;

    // ==========================================================================
    // Link timing
    // The monoflop_time is a typical figure, so its count rounds down.
    localparam int MONOFLOP_TIME_NS = 16000;
    localparam int MONOFLOP_CYC = (MONOFLOP_TIME_NS * SYS_CLK_KHZ) / NS_PER_MS;
    // The inter_frame_pause is a least time, so its count rounds up.
    localparam int INTER_FRAME_PAUSE_NS = 16000;
    localparam int PAUSE_CYC = (INTER_FRAME_PAUSE_NS * SYS_CLK_KHZ + NS_PER_MS - 1) / NS_PER_MS;
    localparam int ZERO_HOLD_US = 100;
    localparam int ZERO_HOLD_CYC = (ZERO_HOLD_US * SYS_CLK_KHZ + US_PER_MS - 1) / US_PER_MS;
    localparam int SCLK_MIN_KHZ = 100;
    localparam int SCLK_MAX_KHZ = 2000;
    localparam int SCLK_DEF_KHZ = 1000;
    localparam int SCLK_HALF_CYC = SYS_CLK_KHZ / (2 * SCLK_DEF_KHZ);
    localparam int EXTRA_CLKS_DEF = 0;

endpackage

// file: ssiap_link_if.sv
// Purpose: The two wires of the serial position link.
// Assumes: Point to point, one master and one encoder.
// Notes: The master drives the clock, the encoder drives the data.
`timescale 1ns/1ps

interface ssiap_link_if;
    logic sclk;
    logic sdata;
    modport dev (input sclk, output sdata);
    modport host (output sclk, input sdata);
endinterface

// file: ssiap_master.sv
// Purpose: Master end of the serial link; clocks out one position frame.
// Assumes: Link clock derived from clk_sys_i by a divider.
// Notes: Data is sampled at the end of each clock-high half.
`timescale 1ns/1ps

module ssiap_master
    import ssiap_pkg::*;
#(
    parameter int RES_BITS = RES_BITS_DEF,
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int EXTRA_CLKS = EXTRA_CLKS_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o,
    output logic [RES_BITS+STATUS_BITS-1:0] word_o,
    ssiap_link_if.host link
);

    // ==========================================================================
    // Local types
    localparam int FRAME_LEN = RES_BITS + STATUS_BITS;
    localparam int RISES = FRAME_LEN + EXTRA_CLKS;
    localparam int RISE_W = $clog2(RISES + 1);
    localparam int TMR_W = $clog2(PAUSE_CYC + HALF_CYC + 1);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH,
        ST_PAUSE
    } ssiap_host_state_type;

    // ==========================================================================
    // Data synchroniser
    logic sdata_m_q;
    logic sdata_s_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sdata_m_q <= 1'b1;
            sdata_s_q <= 1'b1;
        end else begin
            sdata_m_q <= link.sdata;
            sdata_s_q <= sdata_m_q;
        end
    end

    // ==========================================================================
    // Clock divider and frame sequence
    ssiap_host_state_type state_q;
    logic [TMR_W-1:0] tmr_q;
    logic [RISE_W-1:0] rise_q;
    logic sclk_q;
    logic half_end;

    // HALF_CYC sets the link rate; keep it within 100 kHz to 2 MHz.
    assign half_end = (tmr_q == TMR_W'(HALF_CYC - 1));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            tmr_q <= '0;
            rise_q <= '0;
            sclk_q <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_i) begin
                        state_q <= ST_LOW;
                        sclk_q <= 1'b0;
                        tmr_q <= '0;
                        rise_q <= '0;
                    end
                end
                ST_LOW: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (half_end) begin
                        state_q <= ST_HIGH;
                        sclk_q <= 1'b1;
                        tmr_q <= '0;
                        rise_q <= rise_q + 1'b1;
                    end
                end
                ST_HIGH: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (half_end) begin
                        tmr_q <= '0;
                        if (rise_q == RISE_W'(RISES)) begin
                            state_q <= ST_PAUSE;
                        end else begin
                            state_q <= ST_LOW;
                            sclk_q <= 1'b0;
                        end
                    end
                end
                ST_PAUSE: begin
                    tmr_q <= tmr_q + 1'b1;
                    if (tmr_q == TMR_W'(PAUSE_CYC - 1)) begin
                        state_q <= ST_IDLE;
                        tmr_q <= '0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    sclk_q <= 1'b1;
                end
            endcase
        end
    end

    assign link.sclk = sclk_q;

    // ==========================================================================
    // Word assembly; surplus zeros beyond the frame are dropped.
    logic [FRAME_LEN-1:0] shift_q;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_q <= '0;
            word_o <= '0;
            done_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            busy_o <= (state_q != ST_IDLE) || start_i;
            if (state_q == ST_HIGH && half_end && rise_q <= RISE_W'(FRAME_LEN)) begin
                shift_q <= {shift_q[FRAME_LEN-2:0], sdata_s_q};
            end
            if (state_q == ST_HIGH && half_end && rise_q == RISE_W'(RISES)) begin
                done_o <= 1'b1;
                word_o <= (EXTRA_CLKS == 0) ? {shift_q[FRAME_LEN-2:0], sdata_s_q} : shift_q;
            end
        end
    end

endmodule

// file: ssiap_props.sv
// Purpose: Wire level checks on the serial position link.
// Assumes: Both ends run on the same 40 MHz system clock; sclk comes from a flop on it.
// Notes: Sees only the two link wires, so word contents are judged by the bench.
`timescale 1ns/1ps

module ssiap_props
    import ssiap_pkg::*;
#(
    parameter int RES_BITS = RES_BITS_DEF,
    parameter int EXTRA_CLKS = EXTRA_CLKS_DEF
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic sclk,
    input wire logic sdata
);
    // ==========================================================================
    // Helper counters
    logic sclk_q;
    logic [11:0] still_q;
    logic [4:0] rises_q;

    // Saturates so that a long idle never wraps back into the frame range.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b1;
            still_q <= '0;
        end else begin
            sclk_q <= sclk;
            if (sclk != sclk_q) begin
                still_q <= '0;
            end else if (still_q != 12'hfff) begin
                still_q <= still_q + 12'h001;
            end
        end
    end

    // A fall after a long high stretch opens a frame; outside frames the count reads complete.
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rises_q <= 5'(RES_BITS + 1 + EXTRA_CLKS);
        end else if (!sclk && sclk_q && still_q >= 12'h064) begin
            rises_q <= '0;
        end else if (sclk && !sclk_q) begin
            rises_q <= rises_q + 5'h01;
        end
    end

    // ==========================================================================
    // Properties
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence frame_start_s;
        $fell(sclk) && still_q >= 12'h064;
    endsequence

    idle_high_a: assert property (sclk && still_q >= 12'h2bc |-> sdata)
        else $error("data line not high after the monoflop");
    data_stable_a: assert property ($changed(sdata) |-> $rose(sclk) || still_q >= MONOFLOP_CYC)
        else $error("data changed away from a rising clock");
    surplus_zero_a: assert property ($rose(sclk) && rises_q >= RES_BITS + 1 |-> !sdata)
        else $error("surplus clock did not give a zero");
    rise_count_a: assert property (sclk && still_q == 12'h0c8 |-> rises_q == RES_BITS + 1 + EXTRA_CLKS)
        else $error("wrong number of rising edges in frame");
    clk_half_a: assert property ($changed(sclk) |-> still_q >= 12'h009)
        else $error("link clock half period too short");
    clk_low_a: assert property ($rose(sclk) |-> still_q <= 12'h0c7)
        else $error("link clock low phase too long");
    first_low_a: assert property ($fell(sclk) |=> (!sclk) [*8])
        else $error("link clock low phase cut short");
    pause_min_a: assert property (frame_start_s |-> still_q >= PAUSE_CYC - 1)
        else $error("pause between frames too short");
    ready_high_a: assert property (frame_start_s |-> sdata)
        else $error("frame started while data line low");

    frame_seen_c: cover property (frame_start_s);
endmodule

// file: tb_top.sv
// Purpose: Self-checking bench joining the master and encoder ends.
// Assumes: Gray coded 13 bit encoder, master giving two surplus clocks; a second
//          binary pair with no surplus clocks shares the sensor inputs.
// Notes: Words are predicted from the raw count, direction and zero offset.
`timescale 1ns/1ps

module tb_top
    import ssiap_pkg::*;
;
    localparam int RES = 13;
    localparam int EXTRA = 2;
    localparam int LIMIT = 60000;

    logic clk;
    logic rst_n;
    logic [RES-1:0] raw_pos;
    logic pos_valid, supply_ok, nvm_ok, zero_set, dir_sel, start;
    logic link_ready, busy, done;
    logic [RES:0] word;
    logic bin_start, bin_ready, bin_busy, bin_done;
    logic [RES:0] bin_word;
    int failures, samples_checked, cycles;

    ssiap_link_if link_if ();
    ssiap_link_if bin_if ();

    ssiap_device #(.RES_BITS(RES), .GRAY_CODE(1'b1)) ssiap_device_inst (
        .clk_sys_i(clk), .rst_n_i(rst_n), .raw_pos_i(raw_pos), .pos_valid_i(pos_valid),
        .supply_ok_i(supply_ok), .nvm_ok_i(nvm_ok), .zero_set_i(zero_set),
        .dir_sel_i(dir_sel), .link_ready_o(link_ready), .link(link_if.dev));

    ssiap_master #(.RES_BITS(RES), .EXTRA_CLKS(EXTRA)) ssiap_master_inst (
        .clk_sys_i(clk), .rst_n_i(rst_n), .start_i(start), .busy_o(busy),
        .done_o(done), .word_o(word), .link(link_if.host));

    ssiap_props #(.RES_BITS(RES), .EXTRA_CLKS(EXTRA)) ssiap_props_inst (
        .clk_sys_i(clk), .rst_n_i(rst_n), .sclk(link_if.sclk), .sdata(link_if.sdata));

    // The binary pair reaches the other coding and the exact-length frame,
    // which the Gray pair with surplus clocks never exercises.
    if (1) begin : bin_pair
        ssiap_device #(.RES_BITS(RES), .GRAY_CODE(1'b0)) ssiap_device_inst (
            .clk_sys_i(clk), .rst_n_i(rst_n), .raw_pos_i(raw_pos), .pos_valid_i(pos_valid),
            .supply_ok_i(supply_ok), .nvm_ok_i(nvm_ok), .zero_set_i(zero_set),
            .dir_sel_i(dir_sel), .link_ready_o(bin_ready), .link(bin_if.dev));

        ssiap_master #(.RES_BITS(RES), .EXTRA_CLKS(0)) ssiap_master_inst (
            .clk_sys_i(clk), .rst_n_i(rst_n), .start_i(bin_start), .busy_o(bin_busy),
            .done_o(bin_done), .word_o(bin_word), .link(bin_if.host));
    end

    // ==========================================================================
    // Helpers
    function automatic logic [RES-1:0] gray_of(input logic [RES-1:0] b);
        return b ^ (b >> 1);
    endfunction

    task automatic step;
        @(posedge clk);
        #2;
    endtask

    task automatic check_word(input logic [RES:0] got, input logic [RES:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    // The global cycle limit bounds every wait loop here. New inputs get a few
    // cycles to reach the held word, which is only quasi-static at capture.
    task automatic start_frame;
        repeat (4) step();
        while (link_ready !== 1'b1) step();
        start = 1'b1;
        step();
        start = 1'b0;
        check_flag(busy, 1'b1);
    endtask

    // The master ignores a start during its pause, so the pause is sat out here.
    task automatic wait_done(output logic [RES:0] w);
        while (done !== 1'b1) step();
        check_flag(link_ready, 1'b0);
        w = word;
        repeat (PAUSE_CYC) step();
    endtask

    task automatic read_word(input logic [RES-1:0] pos, input logic ok);
        logic [RES:0] w;
        start_frame();
        wait_done(w);
        check_word(w, {gray_of(pos), ok});
    endtask

    // ==========================================================================
    // Scenarios
    task automatic test_codes;
        logic [RES-1:0] tbl [4];
        tbl = '{13'h0000, 13'h1fff, 13'h1555, 13'h0a0a};
        foreach (tbl[i]) begin
            raw_pos = tbl[i];
            read_word(tbl[i], 1'b1);
        end
    endtask

    task automatic test_capture;
        logic [RES:0] w;
        raw_pos = 13'h0123;
        start_frame();
        repeat (100) step();
        raw_pos = 13'h0456;
        wait_done(w);
        check_word(w, {gray_of(13'h0123), 1'b1});
        read_word(13'h0456, 1'b1);
    endtask

    task automatic test_faults;
        logic [RES:0] w;
        for (int k = 0; k < 4; k++) begin
            pos_valid = (k != 1);
            supply_ok = (k != 2);
            nvm_ok = (k != 3);
            start_frame();
            wait_done(w);
            check_flag(w[0], k == 0);
        end
        pos_valid = 1'b1;
        supply_ok = 1'b1;
        nvm_ok = 1'b1;
    endtask

    task automatic test_binary;
        logic [RES-1:0] tbl [2];
        tbl = '{13'h1fff, 13'h1234};
        foreach (tbl[i]) begin
            raw_pos = tbl[i];
            repeat (4) step();
            while (bin_ready !== 1'b1) step();
            bin_start = 1'b1;
            step();
            bin_start = 1'b0;
            check_flag(bin_busy, 1'b1);
            while (bin_done !== 1'b1) step();
            check_flag(bin_ready, 1'b0);
            check_word(bin_word, {tbl[i], 1'b1});
            repeat (PAUSE_CYC) step();
        end
    endtask

    task automatic test_dir;
        dir_sel = 1'b1;
        raw_pos = 13'h0005;
        repeat (8) step();
        read_word(13'h0000 - raw_pos, 1'b1);
        dir_sel = 1'b0;
        repeat (8) step();
    endtask

    // A short press must not zero; a full press zeroes at the current place.
    task automatic test_zero;
        raw_pos = 13'h0064;
        zero_set = 1'b1;
        repeat (200) step();
        zero_set = 1'b0;
        repeat (8) step();
        read_word(13'h0064, 1'b1);
        zero_set = 1'b1;
        repeat (ZERO_HOLD_CYC + 20) step();
        zero_set = 1'b0;
        repeat (8) step();
        read_word(13'h0000, 1'b1);
        raw_pos = 13'h006e;
        read_word(13'h000a, 1'b1);
    endtask

    // ==========================================================================
    // Run control
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            $display("mismatch at %0t: timeout", $time);
            finish_test();
        end
    end

    initial begin
        rst_n = 1'b0;
        raw_pos = '0;
        pos_valid = 1'b1;
        supply_ok = 1'b1;
        nvm_ok = 1'b1;
        zero_set = 1'b0;
        dir_sel = 1'b0;
        start = 1'b0;
        bin_start = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (700) step();
        test_codes();
        test_binary();
        test_capture();
        test_faults();
        test_dir();
        test_zero();
        finish_test();
    end
endmodule
